// [rtl/dic_pkg.sv]
// How it works
// - Eleven sources plus reset, fast dispatch
// - Four dedicated external request inputs
// - Serial port b pins become two requests
// - Internal requests: timer, dma, serial, software, power-down
// - Fixed priority; all maskable except power-down, reset
// - Programmable inputs choose edge or level sensing
// - Level inputs always level; edge input always edge
// - Reset vectors to 0000, highest priority
// - Fixed descending priority order with fixed vectors
// - Serial b shares vectors 0020, 0024 with requests
// - Nested preemption or sequential service selectable
// - Pending ANDed with mask; highest survivor wins
// - Power-down never blocked by mask
// - Block all interrupts one cycle after mask write
// - Mask-write block leaves autobuffer and DMA alone
// - Control word holds nesting and sense bits
// - Software forces and clears edge input request
// - Force/clear word write-only, reads return zero
// - Status stack pushed on entry, popped on exit
// - Status stack twelve deep, shared by all
// - Global enable gates all servicing, even power-down
// - Global disable leaves autobuffer and DMA alone
// - Global enable is on after reset
// - Flag and interrupt functions run together
package dic_pkg;
  // Priority index: 10 (power-down) is highest, 0 (timer) is lowest
  localparam int NLEV = 11;
  localparam int L_PWD = 10;
  localparam int L_PRGA = 9;
  localparam int L_LVLB = 8;
  localparam int L_LVLA = 7;
  localparam int L_SATX = 6;
  localparam int L_SARX = 5;
  localparam int L_EDGE = 4;
  localparam int L_BYTE_DMA_PORT = 3;
  localparam int L_SBTX = 2;
  localparam int L_SBRX = 1;
  localparam int L_TMR = 0;
  // Vector addresses, 14 bits
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_PWD = 14'h002c;
  localparam logic [13:0] VEC_PRGA = 14'h0004;
  localparam logic [13:0] VEC_LVLB = 14'h0008;
  localparam logic [13:0] VEC_LVLA = 14'h000c;
  localparam logic [13:0] VEC_SATX = 14'h0010;
  localparam logic [13:0] VEC_SARX = 14'h0014;
  localparam logic [13:0] VEC_EDGE = 14'h0018;
  localparam logic [13:0] VEC_BYTE_DMA_PORT = 14'h001c;
  localparam logic [13:0] VEC_SBTX = 14'h0020;
  localparam logic [13:0] VEC_SBRX = 14'h0024;
  localparam logic [13:0] VEC_TMR = 14'h0028;
  // APB register byte offsets
  localparam logic [7:0] A_MASK = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_FCLR = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_GEN = 8'h10;
  localparam logic [7:0] A_SPB = 8'h14;
  localparam logic [7:0] A_VEC = 8'h18;
  // Control word fields
  localparam int C_SENSE_A = 0;
  localparam int C_SENSE_B = 1;
  localparam int C_SENSE_C = 2;
  localparam int C_NEST = 4;
  // Force/clear word: force bits low, clear bits high
  localparam int FC_CLR = 16;
  // Reset values
  localparam logic [10:0] MASK_RST = 11'h000;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic GEN_RST = 1'b1;
  localparam int STK_DEPTH = 12;
  localparam int STK_W = 16;
  localparam int SP_W = 4;
endpackage

// [rtl/dic_edge_det.sv]
// Falling edge detector on an active-low request
module dic_edge_det (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic req_n,
  output logic fall
);
  logic prev_q;
  // Idle level is high, so reset to high
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= req_n;
    end
  end
  assign fall = prev_q & ~req_n;
endmodule

// [rtl/dic_stack_mem.sv]
// Status stack storage; read data registered
module dic_stack_mem import dic_pkg::*; (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [dic_pkg::SP_W-1:0] waddr,
  input wire logic [dic_pkg::STK_W-1:0] wdata,
  input wire logic [dic_pkg::SP_W-1:0] raddr,
  output logic [dic_pkg::STK_W-1:0] rdata
);
  logic [STK_W-1:0] mem [STK_DEPTH];
  // No reset: contents valid only once pushed
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// [rtl/dic_top.sv]
// Prioritizing interrupt controller with APB register access
//
// The implementer's own choices: the APB register port and the register offsets.
module dic_top import dic_pkg::*; (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_req_prog_a_n,
  input wire logic ext_req_level_a_n,
  input wire logic ext_req_level_b_n,
  input wire logic ext_req_edge_n,
  input wire logic spb_pin_rfs_n,
  input wire logic spb_pin_tfs_n,
  input wire logic spb_pin_dr,
  input wire logic spb_tx_req,
  input wire logic spb_rx_req,
  input wire logic spa_tx_req,
  input wire logic spa_rx_req,
  input wire logic timer_req,
  input wire logic byte_dma_port_req,
  input wire logic pwd_req,
  input wire logic sw_req,
  input wire logic [3:0] prog_flag_7_to_4_in,
  input wire logic powerup_reset_ctl,
  input wire logic powerup_event,
  input wire logic seq_ack,
  input wire logic seq_rti,
  input wire logic [dic_pkg::STK_W-1:0] seq_status,
  input wire logic seq_push,
  input wire logic seq_pop,
  output logic int_req,
  output logic [13:0] int_vec,
  output logic [dic_pkg::STK_W-1:0] stk_top,
  output logic stk_overflow,
  output logic flag_input_line,
  output logic [3:0] prog_flag_7_to_4_val,
  output logic dma_xfer_allow
);
  // Whole module state
  typedef struct packed {
    logic [10:0] mask;
    logic [4:0] ctrl;
    logic gen_en;
    logic spb_reconf;
    logic mask_blk;
    logic [10:0] edge_pend;
    logic [10:0] in_svc;
    logic req;
    logic [13:0] vec;
    logic [3:0] lvl;
    logic rst_vec;
    logic [SP_W-1:0] sp;
    logic ovf;
    logic [31:0] rdata;
    logic ready;
  } dic_state_t;
  dic_state_t s_q, s_d;

  // Fixed vector per priority level
  function automatic logic [13:0] vec_of(input logic [3:0] l);
    unique case (l)
      4'd10: vec_of = VEC_PWD;
      4'd9: vec_of = VEC_PRGA;
      4'd8: vec_of = VEC_LVLB;
      4'd7: vec_of = VEC_LVLA;
      4'd6: vec_of = VEC_SATX;
      4'd5: vec_of = VEC_SARX;
      4'd4: vec_of = VEC_EDGE;
      4'd3: vec_of = VEC_BYTE_DMA_PORT;
      4'd2: vec_of = VEC_SBTX;
      4'd1: vec_of = VEC_SBRX;
      4'd0: vec_of = VEC_TMR;
      default: vec_of = VEC_RESET;
    endcase
  endfunction

  // Highest set bit index; top bit is highest priority
  function automatic logic [3:0] top_of(input logic [10:0] v);
    top_of = 4'd0;
    for (int i = 0; i < NLEV; i++) begin
      if (v[i]) begin
        top_of = 4'(i);
      end
    end
  endfunction

  // Edge detectors, one per pin that may edge-sense
  logic [3:0] pin_n;
  logic [3:0] fall;
  assign pin_n = {ext_req_prog_a_n, ext_req_edge_n, spb_pin_tfs_n, spb_pin_rfs_n};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_edge
      dic_edge_det u_det (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .req_n(pin_n[g]),
        .fall(fall[g])
      );
    end
  endgenerate

  // Status stack
  logic stk_we;
  logic [SP_W-1:0] stk_raddr;
  logic [STK_W-1:0] stk_rdata;
  dic_stack_mem u_stk (
    .core_clk(core_clk),
    .we(stk_we),
    .waddr(s_q.sp),
    .wdata(seq_status),
    .raddr(stk_raddr),
    .rdata(stk_rdata)
  );

  // Bus decode
  logic wr_acc, rd_acc;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;

  logic [10:0] lvl_pend, edge_set, pend, gated, higher;
  logic entry, any_ok, sp_full;
  logic [3:0] win;
  logic [3:0] cur_lvl;
  logic prgb_level, prgc_level;

  always_comb begin
    s_d = s_q;
    lvl_pend = '0;
    edge_set = '0;
    // Level-sensed sources: pending only while low, never latched
    lvl_pend[L_LVLA] = ~ext_req_level_a_n;
    lvl_pend[L_LVLB] = ~ext_req_level_b_n;
    lvl_pend[L_PRGA] = ~s_q.ctrl[C_SENSE_A] & ~ext_req_prog_a_n;
    prgb_level = s_q.spb_reconf & ~s_q.ctrl[C_SENSE_B] & ~spb_pin_tfs_n;
    prgc_level = s_q.spb_reconf & ~s_q.ctrl[C_SENSE_C] & ~spb_pin_rfs_n;
    // Shared vectors: serial b or pin request by mode
    lvl_pend[L_SBTX] = (~s_q.spb_reconf & spb_tx_req) | prgb_level;
    lvl_pend[L_SBRX] = (~s_q.spb_reconf & spb_rx_req) | prgc_level;
    // Internal sources and pin edges latch as events
    edge_set[L_SATX] = spa_tx_req;
    edge_set[L_SARX] = spa_rx_req;
    edge_set[L_BYTE_DMA_PORT] = byte_dma_port_req;
    edge_set[L_TMR] = timer_req | sw_req;
    edge_set[L_PWD] = pwd_req;
    edge_set[L_EDGE] = fall[2];
    edge_set[L_PRGA] = s_q.ctrl[C_SENSE_A] & fall[3];
    edge_set[L_SBTX] = s_q.spb_reconf & s_q.ctrl[C_SENSE_B] & fall[1];
    edge_set[L_SBRX] = s_q.spb_reconf & s_q.ctrl[C_SENSE_C] & fall[0];
    pend = lvl_pend | s_q.edge_pend;
    // Mask AND; power-down always passes the mask
    gated = pend & (s_q.mask | (11'h001 << L_PWD));
    // Nesting: only levels above the active one may preempt
    cur_lvl = top_of(s_q.in_svc);
    higher = '0;
    for (int i = 0; i < NLEV; i++) begin
      higher[i] = (s_q.in_svc == '0) || (s_q.ctrl[C_NEST] && (4'(i) > cur_lvl));
    end
    gated = gated & higher;
    win = top_of(gated);
    any_ok = (gated != '0) & s_q.gen_en & ~s_q.mask_blk;
    sp_full = (s_q.sp == SP_W'(STK_DEPTH));
    entry = 1'b0;
    stk_we = 1'b0;
    stk_raddr = s_q.sp - SP_W'(1);
    // Request/vector output; reset vector has top priority
    if (s_q.rst_vec) begin
      s_d.req = 1'b1;
      s_d.vec = VEC_RESET;
    end else begin
      s_d.req = any_ok;
      s_d.vec = vec_of(win);
      s_d.lvl = win;
    end
    if (seq_ack && s_q.req) begin
      if (s_q.rst_vec) begin
        // Reset vector taken: drop the request; not an entry, so no status push or in-service bit
        s_d.rst_vec = 1'b0;
        s_d.req = 1'b0;
      end else begin
        entry = 1'b1;
        s_d.in_svc[s_q.lvl] = 1'b1;
        // Taking an edge request returns it to idle
        s_d.edge_pend[s_q.lvl] = 1'b0;
        s_d.req = 1'b0;
      end
    end
    if (powerup_event && powerup_reset_ctl) begin
      s_d.rst_vec = 1'b1;
    end
    // Return from service drops the active level
    if (seq_rti && s_q.in_svc != '0) begin
      s_d.in_svc[cur_lvl] = 1'b0;
    end
    // Automatic status push on entry, pop on return
    if ((entry || seq_push) && !sp_full) begin
      stk_we = 1'b1;
      s_d.sp = s_q.sp + SP_W'(1);
    end else if ((entry || seq_push) && sp_full) begin
      s_d.ovf = 1'b1;
    end else if ((seq_rti || seq_pop) && s_q.sp != '0) begin
      s_d.sp = s_q.sp - SP_W'(1);
    end
    // Mask-write block lasts one cycle
    s_d.mask_blk = 1'b0;
    // Register writes at the access phase
    if (wr_acc) begin
      unique case (paddr)
        A_MASK: begin
          s_d.mask = pwdata[10:0];
          s_d.mask_blk = 1'b1;
        end
        A_CTRL: s_d.ctrl = pwdata[4:0];
        A_FCLR: begin
          // Clear first, then force; hardware sets below win
          s_d.edge_pend = (s_d.edge_pend & ~pwdata[FC_CLR +: NLEV]) | pwdata[10:0];
        end
        A_GEN: s_d.gen_en = pwdata[0];
        A_SPB: s_d.spb_reconf = pwdata[0];
        default: ;
      endcase
    end
    // New events win over any clear in the same cycle
    s_d.edge_pend = s_d.edge_pend | edge_set;
    // Read data
    s_d.rdata = '0;
    if (rd_acc) begin
      unique case (paddr)
        A_MASK: s_d.rdata = {21'h0, s_q.mask};
        A_CTRL: s_d.rdata = {27'h0, s_q.ctrl};
        A_FCLR: s_d.rdata = 32'h0;
        A_STAT: s_d.rdata = {s_q.ovf, 3'h0, s_q.sp, 2'h0, s_q.in_svc, pend};
        A_GEN: s_d.rdata = {31'h0, s_q.gen_en};
        A_SPB: s_d.rdata = {31'h0, s_q.spb_reconf};
        A_VEC: s_d.rdata = {17'h0, s_q.req, 14'(s_q.vec)};
        default: s_d.rdata = 32'h0;
      endcase
    end
    // Two-cycle access: ready one cycle into access phase
    s_d.ready = psel & penable & ~s_q.ready;
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.mask <= MASK_RST;
      s_q.ctrl <= CTRL_RST;
      s_q.gen_en <= GEN_RST;
      s_q.rst_vec <= 1'b1;
      // Reset vector shows during reset, not one cycle late
      s_q.req <= 1'b1;
      s_q.vec <= VEC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = 1'b0;
  assign int_req = s_q.req;
  assign int_vec = s_q.vec;
  assign stk_top = stk_rdata;
  assign stk_overflow = s_q.ovf;
  // Flag input and flags observed alongside interrupts
  assign flag_input_line = spb_pin_dr;
  assign prog_flag_7_to_4_val = prog_flag_7_to_4_in;
  // DMA and autobuffer never gated by blocking or disable
  assign dma_xfer_allow = 1'b1;
endmodule

// [bench/dic_assertions.sv]
// Port-level checks on the controller's APB and service outputs
module dic_assertions import dic_pkg::*; (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic seq_ack,
  input wire logic int_req,
  input wire logic [13:0] int_vec,
  input wire logic stk_overflow,
  input wire logic dma_xfer_allow
);
  // One domain, so one clock and one reset for every check
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_ready_next: assert property (psel && penable && !pready |=> pready)
    else $error("ready did not follow access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready without access");
  a_no_error: assert property (!pslverr)
    else $error("slave error raised");
  a_reset_vec: assert property ($rose(arst_n) |-> int_req && int_vec == VEC_RESET)
    else $error("reset vector missing");
  a_vec_table: assert property (int_req |-> int_vec[1:0] == 2'b00 && int_vec <= VEC_PWD)
    else $error("vector outside table");
  a_ack_clears: assert property (seq_ack && int_req |=> !int_req)
    else $error("request stayed after ack");
  a_dma_free: assert property (dma_xfer_allow)
    else $error("transfers stalled");
  a_ovf_sticky: assert property (stk_overflow |=> stk_overflow)
    else $error("overflow flag lost");
endmodule
bind dic_top dic_assertions u_chk (.core_clk, .arst_n, .psel, .penable, .pready, .pslverr,
  .seq_ack, .int_req, .int_vec, .stk_overflow, .dma_xfer_allow);

// [bench/dic_seq_model.sv]
// Program sequencer stand-in: takes requests, serves, returns
module dic_seq_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic int_req,
  input wire logic [13:0] int_vec,
  input wire logic [3:0] dly,
  output logic seq_ack,
  output logic seq_rti,
  output logic [15:0] seq_status,
  output logic got_stb,
  output logic [13:0] got_vec
);
  logic [3:0] n; // Cycles waited or served
  logic busy; // In a service routine
  // Status word tracks the vector so pushes differ
  assign seq_status = {2'b10, int_vec};
  // Slow answers via dly; service time fixed, no nesting taken
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {seq_ack, seq_rti, got_stb, busy, n} <= '0;
      got_vec <= '0;
    end else begin
      seq_ack <= 1'b0;
      seq_rti <= 1'b0;
      got_stb <= seq_ack;
      n <= n + 4'h1;
      // Vector taken at the edge the ack is sampled
      if (seq_ack) got_vec <= int_vec;
      if (busy && n == 4'h9) begin
        seq_rti <= 1'b1;
        busy <= 1'b0;
        n <= 4'h0;
      end else if (!busy && int_req && n >= dly) begin
        seq_ack <= 1'b1;
        busy <= 1'b1;
        n <= 4'h0;
      end else if (!busy && !int_req) begin
        n <= 4'h0;
      end
    end
  end
endmodule

// [bench/tb_dsp_interrupt_controller.sv]
// Self-checking bench: APB tasks, request stimulus, queued vectors
module tb_dsp_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import dic_pkg::*;
  logic core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, puc = 0, pue = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, m, rs = 32'h3e2c5c1e;
  logic [6:0] pin_n = '1; // Request pins, idle high
  logic [5:0] ev = '0; // One-cycle internal events
  logic [3:0] dly = '0;
  logic pready, seq_ack, seq_rti, int_req, got_stb;
  logic [13:0] int_vec, got_vec;
  logic [15:0] seq_status;
  logic [31:0] vq[$], rq[$]; // Expected vectors and read data
  int bad_count = 0, compares = 0;
  dic_top DUT (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr(), .ext_req_prog_a_n(pin_n[0]), .ext_req_level_a_n(pin_n[1]),
    .ext_req_level_b_n(pin_n[2]), .ext_req_edge_n(pin_n[3]), .spb_pin_rfs_n(pin_n[4]),
    .spb_pin_tfs_n(pin_n[5]), .spb_pin_dr(rs[4]), .spb_tx_req(!pin_n[6]), .spb_rx_req(1'b0),
    .spa_tx_req(ev[0]), .spa_rx_req(ev[1]), .timer_req(ev[2]), .byte_dma_port_req(ev[3]),
    .pwd_req(ev[4]), .sw_req(ev[5]), .prog_flag_7_to_4_in(rs[3:0]), .powerup_reset_ctl(puc),
    .powerup_event(pue), .seq_ack, .seq_rti, .seq_status, .seq_push(1'b0), .seq_pop(1'b0),
    .int_req, .int_vec, .stk_top(), .stk_overflow(), .flag_input_line(),
    .prog_flag_7_to_4_val(), .dma_xfer_allow());
  dic_seq_model u_seq (.core_clk, .arst_n, .int_req, .int_vec, .dly, .seq_ack, .seq_rti,
    .seq_status, .got_stb, .got_vec);
  // Clock, 25 ns period
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Random flag and data-pin levels every cycle
  always @(posedge core_clk) rs <= lf(rs);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Outputs compared against the oldest note; empty queue means spurious
  always @(posedge core_clk) begin
    if (got_stb === 1'b1) chk({18'h0, got_vec}, vq.size() ? vq.pop_front() : '1);
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk(prdata, rq.size() ? rq.pop_front() : '1);
  end
  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    summarize();
  end
  // Setup, then access held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, '0);
  endtask
  task automatic ex(input logic [13:0] v);
    vq.push_back({18'h0, v});
  endtask
  // Wait till only k notes remain, then let service finish
  task automatic drain(input int k);
    while (vq.size() > k) @(posedge core_clk);
    repeat (14) @(posedge core_clk);
  endtask
  task automatic pev(input logic [5:0] e);
    @(posedge core_clk) ev <= e;
    @(posedge core_clk) ev <= '0;
  endtask
  // Level held until taken; edge held long so a repeat would show
  task automatic lvl(input int i, input logic [13:0] v);
    ex(v);
    pin_n[i] <= 1'b0;
    do @(posedge core_clk); while (seq_ack !== 1'b1);
    pin_n[i] <= 1'b1;
    drain(0);
  endtask
  task automatic edg(input int i, input logic [13:0] v);
    ex(v);
    pin_n[i] <= 1'b0;
    repeat (30) @(posedge core_clk);
    pin_n[i] <= 1'b1;
    drain(0);
  endtask
  initial begin
    ex(VEC_RESET);
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(A_MASK, 32'h0);
    rd(A_CTRL, 32'h0);
    rd(A_GEN, 32'h1);
    apb(1'b1, A_FCLR, 32'h07ff_0000);
    rd(A_FCLR, 32'h0);
    rd(8'h1c, 32'h0);
    m = rs;
    apb(1'b1, A_MASK, m);
    rd(A_MASK, m & 32'h7ff);
    apb(1'b1, A_MASK, 32'h7ff);
    ex(VEC_SATX);
    ex(VEC_BYTE_DMA_PORT);
    ex(VEC_TMR);
    pev(6'b001101);
    drain(0);
    ex(VEC_TMR);
    pev(6'b100000);
    drain(0);
    dly <= 4'h5;
    apb(1'b1, A_MASK, 32'h0);
    ex(VEC_PWD);
    ex(VEC_TMR);
    pev(6'b010100);
    drain(1);
    apb(1'b1, A_MASK, 32'h7ff);
    drain(0);
    apb(1'b1, A_GEN, 32'h0);
    ex(VEC_PWD);
    pev(6'b010000);
    pin_n[1] <= 1'b0;
    repeat (20) @(posedge core_clk);
    pin_n[1] <= 1'b1;
    drain(1);
    apb(1'b1, A_GEN, 32'h1);
    drain(0);
    lvl(2, VEC_LVLB);
    lvl(1, VEC_LVLA);
    edg(3, VEC_EDGE);
    lvl(0, VEC_PRGA);
    apb(1'b1, A_CTRL, 32'h7);
    edg(0, VEC_PRGA);
    apb(1'b1, A_SPB, 32'h1);
    edg(5, VEC_SBTX);
    edg(4, VEC_SBRX);
    apb(1'b1, A_SPB, 32'h0);
    lvl(6, VEC_SBTX);
    ex(VEC_EDGE);
    apb(1'b1, A_FCLR, 32'h10);
    drain(0);
    apb(1'b1, A_MASK, 32'h7ef);
    apb(1'b1, A_FCLR, 32'h10);
    apb(1'b1, A_FCLR, 32'h0010_0000);
    apb(1'b1, A_MASK, 32'h7ff);
    drain(0);
    puc <= 1'b1;
    ex(VEC_RESET);
    @(posedge core_clk) pue <= 1'b1;
    @(posedge core_clk) pue <= 1'b0;
    drain(0);
    ex(VEC_RESET);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    drain(0);
    rd(A_GEN, 32'h1);
    summarize();
  end
endmodule
